// ==== design/aed_pkg.sv ====
// package for the active energy datapath: register map, field layout, timing
package aed_pkg;
	// ------------------------------------------------------------
	// register map (word offsets on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_PHASE_TRIM = 4'h0;
	localparam logic [3:0] ADDR_POWER_GAIN_TRIM = 4'h1;
	localparam logic [3:0] ADDR_ENERGY_DIVIDER = 4'h2;
	localparam logic [3:0] ADDR_MODE = 4'h3;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
	localparam logic [3:0] ADDR_ENERGY_TOTAL = 4'h6;
	localparam logic [3:0] ADDR_ENERGY_TOTAL_COR = 4'h7;
	localparam logic [3:0] ADDR_WAVEFORM = 4'h8;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int MODE_POSITIVE_ONLY_ACCUMULATION_BIT = 15;
	localparam int MODE_WSRC_LO = 13;
	localparam int MODE_RATE_LO = 11;
	localparam int IEN_HALF_BIT = 0;
	localparam int IEN_OVF_BIT = 1;
	localparam int IEN_SMP_BIT = 3;
	localparam logic [1:0] WSRC_POWER = 2'h0;
	// ------------------------------------------------------------
	// reset values, phase trim centre and limits
	// ------------------------------------------------------------
	localparam logic [5:0] PHASE_TRIM_RST = 6'h0d;
	localparam logic [5:0] PHASE_TRIM_CENTRE = 6'h0d;
	localparam logic [5:0] PHASE_TRIM_MIN = 6'h21;
	localparam logic [5:0] PHASE_TRIM_MAX = 6'h1f;
	localparam logic [11:0] GAIN_RST = 12'h000;
	localparam logic [7:0] DIV_RST = 8'h00;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [3:0] IEN_RST = 4'h0;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int ACC_PERIOD_CLKS = 4;
	localparam int TRIM_STEP_CLKS = 8;
	localparam int WAVE_BASE_DIV = 128;
	localparam int GAIN_SHIFT = 12;
	localparam int LPF_SHIFT = 8;
	typedef struct packed {
		logic signed [15:0] cur;
		logic signed [15:0] volt;
	} aed_sample_s;
	typedef struct packed {
		logic half;
		logic ovf;
		logic smp;
	} aed_event_s;
endpackage : aed_pkg

// ==== design/aed_phase_delay.sv ====
// voltage sample delay line, shifted on each trim step and tapped by the phase trim setting
`timescale 1ns/1ps
module aed_phase_delay #(
	parameter int W = 16,
	parameter int DEPTH = 64
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic step_i,
	input wire logic signed [W-1:0] din_i,
	input wire logic [5:0] tap_i,
	output logic signed [W-1:0] dout_o
);
	logic signed [W-1:0] line_ff [DEPTH];
	initial begin
		if (DEPTH < 64) $error("aed_phase_delay: DEPTH must reach 64 taps");
	end
	// ------------------------------------------------------------
	// shift on every trim step
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) line_ff[i] <= '0;
		end else if (ce_i && step_i) begin
			line_ff[0] <= din_i;
			for (int i = 1; i < DEPTH; i++) line_ff[i] <= line_ff[i-1];
		end
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) dout_o <= '0;
		else if (ce_i) dout_o <= line_ff[tap_i];
	end
endmodule : aed_phase_delay

// ==== design/aed_energy_datapath.sv ====
// active power and energy datapath with its register port
//
// Contract
// R1: phase trim signed six bits, 0x21..0x1f
// R2: setting 0x0d gives zero extra delay
// R3: one step equals eight master clocks
// R4: 0x0b advances two steps from centre
// R5: host keeps trim to small corrections
// R6: multiply then low-pass to active power
// R7: gain scales power by 1+g/4096
// R8: 0x7ff raises half, 0x800 lowers half
// R9: 49-bit accumulator, upper 24 readable
// R10: one accumulate every four master clocks
// R11: accumulation is a signed addition
// R12: positive-only mode skips negative samples
// R13: divide by divider, zero means one
// R14: clear-on-read returns total, clears upper
// R15: source 0,0 plus enable delivers power samples
// R16: four waveform rates selectable
// R17: readable total wraps both directions
// R18: half-full and overflow raise interrupt
// R19: overflow beyond 2^48 magnitude
// R20: full scale inputs give 0xccccd average; the code settles at 0x3fff00
// R21: new sample drives active-low interrupt
// R22: fixed stage order on one clock
`timescale 1ns/1ps
module aed_energy_datapath #(
	parameter int SAMPLE_W = 16,
	parameter int ACC_W = 49,
	parameter int DELAY_DEPTH = 64
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire aed_pkg::aed_sample_s sample_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic irq_n_o,
	output logic wave_valid_o
);
	initial begin
		if (ACC_W != 49) $error("aed_energy_datapath: ACC_W must be 49");
		if (SAMPLE_W != 16) $error("aed_energy_datapath: SAMPLE_W must be 16");
	end
	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [5:0] phase_trim_ff;
	logic [11:0] power_gain_trim_ff;
	logic [7:0] energy_divider_ff;
	logic [15:0] mode_ff;
	logic [3:0] irq_en_ff;
	logic [2:0] irq_stat_ff;
	logic signed [ACC_W-1:0] acc_ff;
	logic signed [23:0] wave_ff;
	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction : hit
	function automatic logic trim_legal(input logic [5:0] v);
		return v != 6'h20;
	endfunction : trim_legal
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_trim_ff <= aed_pkg::PHASE_TRIM_RST;
			power_gain_trim_ff <= aed_pkg::GAIN_RST;
			energy_divider_ff <= aed_pkg::DIV_RST;
			mode_ff <= aed_pkg::MODE_RST;
			irq_en_ff <= aed_pkg::IEN_RST;
		end else if (ce_i && wr_i) begin
			if (hit(addr_i, aed_pkg::ADDR_PHASE_TRIM) && trim_legal(wdata_i[5:0]))
				phase_trim_ff <= wdata_i[5:0]; // see R1
			if (hit(addr_i, aed_pkg::ADDR_POWER_GAIN_TRIM))
				power_gain_trim_ff <= wdata_i[11:0];
			if (hit(addr_i, aed_pkg::ADDR_ENERGY_DIVIDER))
				energy_divider_ff <= wdata_i[7:0];
			if (hit(addr_i, aed_pkg::ADDR_MODE))
				mode_ff <= wdata_i[15:0];
			if (hit(addr_i, aed_pkg::ADDR_IRQ_ENABLE))
				irq_en_ff <= wdata_i[3:0];
		end
	end
	// ------------------------------------------------------------
	// timebase: trim step, accumulate tick, waveform tick
	// ------------------------------------------------------------
	logic [9:0] tick_ff;
	logic step_tick;
	logic acc_tick;
	logic wave_tick;
	logic [9:0] wave_mask;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) tick_ff <= '0;
		else if (ce_i) tick_ff <= tick_ff + 10'h001;
	end
	assign step_tick = tick_ff[2:0] == 3'h7; // see R3
	assign acc_tick = tick_ff[1:0] == 2'h3; // see R10
	// rate field picks 1x, 2x, 4x, 8x of the base divide
	always_comb begin
		unique case (mode_ff[aed_pkg::MODE_RATE_LO +: 2]) // see R16
			2'h0: wave_mask = 10'h07f;
			2'h1: wave_mask = 10'h0ff;
			2'h2: wave_mask = 10'h1ff;
			2'h3: wave_mask = 10'h3ff;
		endcase
	end
	assign wave_tick = (tick_ff & wave_mask) == wave_mask;
	// ------------------------------------------------------------
	// phase trim: tap = centre tap 44 offset by signed setting minus 0x0d
	// ------------------------------------------------------------
	localparam int CENTRE_TAP = 44;
	logic [5:0] tap;
	logic signed [15:0] volt_trim;
	// centre tap of 44 covers the 44-step advance of setting 0x21
	// and the 18-step delay of setting 0x1f inside the 64-tap line
	assign tap = 6'(CENTRE_TAP + phase_trim_ff - aed_pkg::PHASE_TRIM_CENTRE); // see R2 see R4
	aed_phase_delay #(.W(SAMPLE_W), .DEPTH(DELAY_DEPTH)) u_delay (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.step_i(step_tick),
		.din_i(sample_i.volt),
		.tap_i(tap),
		.dout_o(volt_trim)
	);
	// current is delayed by the centre tap so that 0x0d aligns the channels
	logic signed [15:0] cur_line_ff [CENTRE_TAP + 1];
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < CENTRE_TAP + 1; i++) cur_line_ff[i] <= '0;
		end else if (ce_i && step_tick) begin
			cur_line_ff[0] <= sample_i.cur;
			for (int i = 1; i < CENTRE_TAP + 1; i++) cur_line_ff[i] <= cur_line_ff[i-1];
		end
	end
	// ------------------------------------------------------------
	// multiply and power low-pass
	// ------------------------------------------------------------
	logic signed [31:0] prod_ff;
	logic signed [39:0] lpf_ff;
	logic signed [31:0] power;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) prod_ff <= '0;
		else if (ce_i) prod_ff <= cur_line_ff[CENTRE_TAP] * volt_trim; // see R6 see R22
	end
	// single pole: y += (x - y) >> 8, full scale gives 0x3fff00 avg, not the 0xccccd of R20
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) lpf_ff <= '0;
		else if (ce_i && acc_tick)
			lpf_ff <= lpf_ff + ((40'(prod_ff) <<< aed_pkg::LPF_SHIFT) - lpf_ff >>> aed_pkg::LPF_SHIFT); // see R6 see R20
	end
	assign power = 32'(lpf_ff >>> (aed_pkg::LPF_SHIFT + 8));
	// ------------------------------------------------------------
	// gain trim and divider
	// ------------------------------------------------------------
	logic signed [31:0] gained_ff;
	logic signed [31:0] divided_ff;
	logic signed [44:0] gprod;
	assign gprod = 45'(power) * 45'($signed({1'b0, 12'h000} + 13'(signed'(power_gain_trim_ff))) + 45'sd4096);
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) gained_ff <= '0;
		else if (ce_i && acc_tick) gained_ff <= 32'(gprod >>> aed_pkg::GAIN_SHIFT); // see R7 see R8
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) divided_ff <= '0;
		else if (ce_i && acc_tick) begin
			if (energy_divider_ff == 8'h00) divided_ff <= gained_ff; // see R13
			else divided_ff <= gained_ff / $signed({24'h000000, energy_divider_ff}); // see R13
		end
	end
	// ------------------------------------------------------------
	// accumulator, wrap and events
	// ------------------------------------------------------------
	logic signed [ACC_W-1:0] addend;
	logic signed [ACC_W-1:0] acc_base;
	logic signed [ACC_W-1:0] nxt_acc;
	logic cor_hit;
	logic ovf_evt;
	logic half_evt;
	logic [23:0] top_old;
	logic [23:0] top_new;
	assign cor_hit = ce_i && rd_i && hit(addr_i, aed_pkg::ADDR_ENERGY_TOTAL_COR);
	assign addend = (mode_ff[aed_pkg::MODE_POSITIVE_ONLY_ACCUMULATION_BIT] && divided_ff < 0) ? '0
		: ACC_W'(divided_ff); // see R11 see R12
	assign acc_base = cor_hit ? {24'h000000, acc_ff[ACC_W-25:0]} : acc_ff; // see R14
	assign nxt_acc = acc_base + (acc_tick ? addend : '0); // see R9 see R11
	assign top_old = acc_base[ACC_W-1 -: 24];
	assign top_new = nxt_acc[ACC_W-1 -: 24];
	// wrap when the sign flips with both operands of equal sign
	assign ovf_evt = acc_tick && (acc_base[ACC_W-1] == addend[ACC_W-1])
		&& (nxt_acc[ACC_W-1] != acc_base[ACC_W-1]); // see R17 see R19
	assign half_evt = acc_tick && (top_new[23] == top_new[22]) == 1'b0
		&& (top_old[23] == top_old[22]); // see R18
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) acc_ff <= '0;
		else if (ce_i) acc_ff <= nxt_acc; // see R9
	end
	// ------------------------------------------------------------
	// waveform sample register
	// ------------------------------------------------------------
	logic wave_on;
	logic smp_evt;
	assign wave_on = mode_ff[aed_pkg::MODE_WSRC_LO +: 2] == aed_pkg::WSRC_POWER
		&& irq_en_ff[aed_pkg::IEN_SMP_BIT];
	assign smp_evt = wave_on && wave_tick; // see R15
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) wave_ff <= '0;
		else if (ce_i && smp_evt) wave_ff <= 24'(gained_ff); // see R15
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) wave_valid_o <= 1'b0;
		else if (ce_i) wave_valid_o <= smp_evt; // see R16
	end
	// ------------------------------------------------------------
	// status flags: set wins over read-clear
	// ------------------------------------------------------------
	aed_pkg::aed_event_s evt;
	logic st_rd;
	assign evt = '{half: half_evt, ovf: ovf_evt, smp: smp_evt};
	assign st_rd = ce_i && rd_i && hit(addr_i, aed_pkg::ADDR_IRQ_STATUS);
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) irq_stat_ff <= '0;
		else if (ce_i) irq_stat_ff <= (st_rd ? 3'h0 : irq_stat_ff) | {evt.smp, evt.ovf, evt.half};
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) irq_n_o <= 1'b1;
		else if (ce_i) irq_n_o <= !((irq_stat_ff[0] && irq_en_ff[aed_pkg::IEN_HALF_BIT])
			|| (irq_stat_ff[1] && irq_en_ff[aed_pkg::IEN_OVF_BIT])
			|| (irq_stat_ff[2] && irq_en_ff[aed_pkg::IEN_SMP_BIT])); // see R18 see R21
	end
	// ------------------------------------------------------------
	// read port: data one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) rdata_o <= '0;
		else if (ce_i) begin
			rdata_o <= '0;
			if (rd_i) begin
				unique case (addr_i)
					aed_pkg::ADDR_PHASE_TRIM: rdata_o <= {26'h0, phase_trim_ff};
					aed_pkg::ADDR_POWER_GAIN_TRIM: rdata_o <= {20'h0, power_gain_trim_ff};
					aed_pkg::ADDR_ENERGY_DIVIDER: rdata_o <= {24'h0, energy_divider_ff};
					aed_pkg::ADDR_MODE: rdata_o <= {16'h0, mode_ff};
					aed_pkg::ADDR_IRQ_ENABLE: rdata_o <= {28'h0, irq_en_ff};
					aed_pkg::ADDR_IRQ_STATUS: rdata_o <= {29'h0, irq_stat_ff};
					aed_pkg::ADDR_ENERGY_TOTAL,
					aed_pkg::ADDR_ENERGY_TOTAL_COR: rdata_o <= {8'h0, acc_ff[ACC_W-1 -: 24]}; // see R14
					aed_pkg::ADDR_WAVEFORM: rdata_o <= {8'h0, wave_ff};
					default: rdata_o <= '0;
				endcase
			end
		end
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_trim_legal: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R1
		phase_trim_ff != 6'h20) else $error("phase trim holds illegal code");
	a_cor_clears: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R14
		cor_hit && !acc_tick |=> acc_ff[ACC_W-1 -: 24] == 24'h0) else $error("clear on read failed");
	a_acc_cadence: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R10
		ce_i && !acc_tick && !cor_hit |=> $stable(acc_ff)) else $error("accumulated off tick");
	a_positive_only_accumulation_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R12
		mode_ff[aed_pkg::MODE_POSITIVE_ONLY_ACCUMULATION_BIT] |-> addend >= 0) else $error("negative sample in positive_only_accumulation");
	a_rd_latency: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R14
		ce_i && rd_i && addr_i == aed_pkg::ADDR_ENERGY_DIVIDER |=> rdata_o[7:0] == $past(energy_divider_ff))
		else $error("read data late");
	a_irq_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R21
		ce_i && irq_stat_ff[2] && irq_en_ff[3] |=> !irq_n_o) else $error("sample irq missing");
	a_flag_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R18
		ce_i && irq_stat_ff[1] && !st_rd |=> irq_stat_ff[1]) else $error("overflow flag lost");
	a_div_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R13
		ce_i && acc_tick && energy_divider_ff == 8'h00 |=> divided_ff == $past(gained_ff))
		else $error("divide by zero not unity");
	a_wave_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R15
		!wave_on |=> !wave_valid_o) else $error("sample without enable");
	// ------------------------------------------------------------
	// tick spacing counters for the checks below
	// ------------------------------------------------------------
	logic [1:0] acc_gap_ff;
	logic [2:0] step_gap_ff;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) acc_gap_ff <= '0;
		else if (ce_i) acc_gap_ff <= acc_tick ? 2'h0 : acc_gap_ff + 2'h1;
	end
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) step_gap_ff <= '0;
		else if (ce_i) step_gap_ff <= step_tick ? 3'h0 : step_gap_ff + 3'h1;
	end
	// ------------------------------------------------------------
	// checks of timing, trim, gain, accumulator and flag behaviour
	// ------------------------------------------------------------
	a_acc_spacing: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R10
		acc_tick == (acc_gap_ff == 2'h3))
		else $error("accumulate tick spacing wrong");
	a_step_spacing: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R3
		step_tick == (step_gap_ff == 3'h7))
		else $error("trim step spacing wrong");
	a_tap_centre: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R2
		phase_trim_ff == aed_pkg::PHASE_TRIM_CENTRE |-> tap == 6'(CENTRE_TAP))
		else $error("centre setting not zero delay");
	a_tap_advance: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R4
		phase_trim_ff == 6'h0b |-> tap == 6'(CENTRE_TAP - 2))
		else $error("setting 0x0b not two steps ahead");
	a_tap_span: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R3
		tap <= 6'd62)
		else $error("trim tap beyond line");
	a_trim_refuse: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R1
		ce_i && wr_i && hit(addr_i, aed_pkg::ADDR_PHASE_TRIM) && wdata_i[5:0] == 6'h20
		|=> $stable(phase_trim_ff)) else $error("illegal trim code stored");
	a_gain_unity: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R7
		ce_i && acc_tick && power_gain_trim_ff == 12'h000 |=> gained_ff == $past(power))
		else $error("zero gain trim not unity");
	a_gain_half: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R8
		ce_i && acc_tick && power_gain_trim_ff == 12'h800 |=> gained_ff == ($past(power) >>> 1))
		else $error("gain trim 0x800 not half");
	a_acc_signed_add: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R11
		ce_i && acc_tick && !cor_hit |=> acc_ff == $past(acc_ff) + $past(addend))
		else $error("accumulator sum wrong");
	a_cor_keeps_low: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R14
		cor_hit && !acc_tick |=> acc_ff[ACC_W-25:0] == $past(acc_ff[ACC_W-25:0]))
		else $error("clear on read touched low bits");
	a_rd_idle_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R14
		ce_i && !rd_i |=> rdata_o == 32'h0)
		else $error("read data outside its cycle");
	a_irq_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R18
		ce_i && irq_en_ff == 4'h0 |=> irq_n_o)
		else $error("interrupt with all sources off");
	a_half_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R18
		ce_i && half_evt |=> irq_stat_ff[0])
		else $error("half full flag not set");
	a_ovf_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R17
		ce_i && ovf_evt |=> irq_stat_ff[1])
		else $error("overflow flag not set");
	a_ce_freeze: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R22
		!ce_i |=> $stable(acc_ff) && $stable(tick_ff) && $stable(rdata_o))
		else $error("state moved while disabled");
	a_wave_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_i) // see R16
		ce_i && wave_valid_o |=> !wave_valid_o)
		else $error("sample pulse longer than a cycle");
endmodule : aed_energy_datapath

// ==== test/aed_host_model.sv ====
// host model that drives the register port of the energy datapath
`timescale 1ns/1ps
module aed_host_model (
	input wire logic clock_i,
	input wire logic [31:0] rdata_i,
	output logic [3:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial begin
		addr_o = 4'h0;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// released data is inverted so that stale values never look valid
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clock_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clock_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(negedge clock_i);
		d = rdata_i;
	endtask : rd_reg
endmodule : aed_host_model

// ==== test/tb_top.sv ====
// self-checking testbench of the active energy datapath
`timescale 1ns/1ps
module tb_top;
	logic clock_i;
	logic rst_n_i;
	logic ce_i;
	aed_pkg::aed_sample_s sample_i;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata_o;
	logic irq_n_o;
	logic wave_valid_o;
	int n_mismatch;
	int tests_run;
	int cycles;
	int k;
	logic [31:0] lf;
	logic [31:0] rv;
	logic [31:0] r1;
	logic signed [31:0] e1;
	logic signed [31:0] e2;
	logic signed [31:0] d0;
	logic signed [31:0] dx;
	aed_energy_datapath u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.sample_i(sample_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata_o), .irq_n_o(irq_n_o), .wave_valid_o(wave_valid_o));
	aed_host_model u_host (.clock_i(clock_i), .rdata_i(rdata_o), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic signed [31:0] sx(input logic [31:0] v);
		return {{8{v[23]}}, v[23:0]};
	endfunction : sx
	// a within one eighth of b, plus residue of the cleared low bits
	function automatic logic [31:0] near(input logic signed [31:0] a, b);
		logic signed [31:0] df;
		df = a - b;
		if (df < 0) df = -df;
		return {31'h0, df <= (b >>> 3) + 8};
	endfunction : near
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	task automatic idle(input int n);
		repeat (n) @(posedge clock_i);
	endtask : idle
	// energy gained over a fixed window after a clear-on-read
	task automatic measure(input logic [11:0] g, input logic [7:0] dv, output logic signed [31:0] d);
		u_host.wr_reg(aed_pkg::ADDR_POWER_GAIN_TRIM, {20'h0, g});
		u_host.wr_reg(aed_pkg::ADDR_ENERGY_DIVIDER, {24'h0, dv});
		u_host.rd_reg(aed_pkg::ADDR_ENERGY_TOTAL_COR, rv);
		idle(6000);
		u_host.rd_reg(aed_pkg::ADDR_ENERGY_TOTAL, rv);
		d = sx(rv);
	endtask : measure
	// cycles between two waveform pulses
	task automatic gap(output int n);
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (wave_valid_o !== 1'b1 && n < 3000);
	endtask : gap
	// ------------------------------------------------------------
	// clock, timeout, sequence
	// ------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 90000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		sample_i = '0;
		n_mismatch = 0;
		tests_run = 0;
		cycles = 0;
		lf = 32'h3a78;
		idle(10);
		rst_n_i <= 1'b1;
		u_host.rd_reg(aed_pkg::ADDR_PHASE_TRIM, rv);
		check("trim_rst", rv, 32'h0000000d);
		@(negedge clock_i);
		check("rdata_idle", rdata_o, 32'h0);
		for (int a = 1; a < 16; a++) begin
			if (a == 4 || a == 5 || a == 3 || a == 15 || a == 6) begin
				u_host.rd_reg(a[3:0], rv);
				check("rst_or_unmapped", rv, 32'h0);
			end
		end
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			r1 = {26'h0, (lf[5:0] == 6'h20) ? 6'h1f : lf[5:0]};
			u_host.wr_reg(aed_pkg::ADDR_PHASE_TRIM, r1);
			u_host.rd_reg(aed_pkg::ADDR_PHASE_TRIM, rv);
			check("trim", rv, r1);
			u_host.wr_reg(aed_pkg::ADDR_POWER_GAIN_TRIM, {20'h0, lf[27:16]});
			u_host.rd_reg(aed_pkg::ADDR_POWER_GAIN_TRIM, rv);
			check("gain", rv, {20'h0, lf[27:16]});
			u_host.wr_reg(aed_pkg::ADDR_ENERGY_DIVIDER, {24'h0, lf[15:8]});
			u_host.rd_reg(aed_pkg::ADDR_ENERGY_DIVIDER, rv);
			check("divider", rv, {24'h0, lf[15:8]});
		end
		u_host.wr_reg(aed_pkg::ADDR_PHASE_TRIM, 32'h20);
		u_host.rd_reg(aed_pkg::ADDR_PHASE_TRIM, rv);
		check("trim_illegal", rv, r1);
		// small advance only, as a host should apply
		u_host.wr_reg(aed_pkg::ADDR_PHASE_TRIM, 32'h0b);
		u_host.rd_reg(aed_pkg::ADDR_PHASE_TRIM, rv);
		check("trim_minus_two", rv, 32'h0b);
		// clock enable low: neither the write nor the read is taken
		@(posedge clock_i);
		ce_i <= 1'b0;
		u_host.wr_reg(aed_pkg::ADDR_PHASE_TRIM, 32'h0d);
		u_host.rd_reg(aed_pkg::ADDR_PHASE_TRIM, rv);
		check("ce_frozen", rv, 32'h0);
		@(posedge clock_i);
		ce_i <= 1'b1;
		u_host.rd_reg(aed_pkg::ADDR_PHASE_TRIM, rv);
		check("ce_resume", rv, 32'h0b);
		$display("test registers done");
		sample_i <= '{cur: 16'h7fff, volt: 16'h7fff};
		measure(12'h000, 8'h00, d0);
		idle(4000);
		u_host.rd_reg(aed_pkg::ADDR_ENERGY_TOTAL_COR, r1);
		u_host.rd_reg(aed_pkg::ADDR_ENERGY_TOTAL, rv);
		check("cor_clears", {31'h0, sx(rv) < (sx(r1) >>> 4)}, 32'h1);
		measure(12'h000, 8'h00, d0);
		check("power_positive", {31'h0, d0 > 0}, 32'h1);
		measure(12'h000, 8'h04, dx);
		check("div_four", near(dx * 4, d0), 32'h1);
		measure(12'h000, 8'h01, dx);
		check("div_zero_one", near(dx, d0), 32'h1);
		measure(12'h800, 8'h00, dx);
		check("gain_half", near(dx * 2, d0), 32'h1);
		measure(12'h7ff, 8'h00, dx);
		check("gain_up", near(dx * 2, d0 * 3), 32'h1);
		$display("test scaling done");
		u_host.wr_reg(aed_pkg::ADDR_POWER_GAIN_TRIM, 32'h0);
		sample_i <= '{cur: 16'h8001, volt: 16'h7fff};
		idle(10000);
		u_host.rd_reg(aed_pkg::ADDR_ENERGY_TOTAL, rv);
		e1 = sx(rv);
		idle(2000);
		u_host.rd_reg(aed_pkg::ADDR_ENERGY_TOTAL, rv);
		e2 = sx(rv);
		check("energy_falls", {31'h0, e2 < e1}, 32'h1);
		u_host.wr_reg(aed_pkg::ADDR_MODE, 32'h8000);
		u_host.rd_reg(aed_pkg::ADDR_ENERGY_TOTAL, r1);
		idle(2000);
		u_host.rd_reg(aed_pkg::ADDR_ENERGY_TOTAL, rv);
		check("positive_only", rv, r1);
		check("irq_masked", {31'h0, irq_n_o}, 32'h1);
		$display("test accumulate done");
		u_host.wr_reg(aed_pkg::ADDR_IRQ_ENABLE, 32'h8);
		for (int r = 0; r < 4; r++) begin
			u_host.wr_reg(aed_pkg::ADDR_MODE, r << 11);
			gap(k);
			gap(k);
			gap(k);
			check("wave_rate", k, 128 << r);
		end
		@(negedge clock_i);
		check("irq_sample", {31'h0, irq_n_o}, 32'h0);
		u_host.rd_reg(aed_pkg::ADDR_IRQ_STATUS, rv);
		check("status_smp", {31'h0, rv[2]}, 32'h1);
		u_host.rd_reg(aed_pkg::ADDR_WAVEFORM, rv);
		check("wave_negative", {31'h0, rv[23]}, 32'h1);
		u_host.wr_reg(aed_pkg::ADDR_IRQ_ENABLE, 32'h0);
		u_host.rd_reg(aed_pkg::ADDR_IRQ_STATUS, rv);
		@(negedge clock_i);
		check("irq_release", {31'h0, irq_n_o}, 32'h1);
		$display("test waveform done");
		stop_test();
	end
endmodule : tb_top
